// File: common/ssu_pkg.sv
// Package for the synchronous serial unit SPI port
package ssu_pkg;

  // ----------------------------------------------------------------
  // Mode field encodings
  // ----------------------------------------------------------------
  localparam logic [3:0] MODE_MST_DIV4  = 4'h0;
  localparam logic [3:0] MODE_MST_DIV16 = 4'h1;
  localparam logic [3:0] MODE_MST_DIV64 = 4'h2;
  localparam logic [3:0] MODE_MST_TMR2  = 4'h3;
  localparam logic [3:0] MODE_SLV_SS    = 4'h4;
  localparam logic [3:0] MODE_SLV_NOSS  = 4'h5;
  localparam logic [3:0] MODE_MST_RELD  = 4'ha;

  // ----------------------------------------------------------------
  // Counts and reset values
  // ----------------------------------------------------------------
  localparam int          BYTE_BITS   = 8;
  localparam logic [3:0]  BIT_LAST    = 4'h8;
  localparam logic [7:0]  DIV4_HALF   = 8'h02;
  localparam logic [7:0]  DIV16_HALF  = 8'h08;
  localparam logic [7:0]  DIV64_HALF  = 8'h20;
  localparam logic [7:0]  BYTE_RST    = 8'h00;
  localparam int          FIFO_DEPTH  = 8;
  localparam int          FIFO_AW     = 3;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       enable;
    logic [3:0] mode;
    logic       idle_high;
    logic       sample_end;
    logic       edge_sel;
  } ssu_cfg_t;

  typedef struct packed {
    logic       buffer_full;
    logic       write_collision;
    logic       busy;
  } ssu_stat_t;

endpackage

// File: design/ssu_fifo.sv
// Receive FIFO with valid/ready on both sides
`timescale 1ns/1ps
module ssu_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8,
  parameter int AW    = 3
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_b,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
  logic [AW:0]      cnt_q, cnt_d;
  logic             push, pop;

  // ----------------------------------------------------------------
  // Pointers
  // ----------------------------------------------------------------
  always_comb begin
    push     = in_valid && in_ready;
    pop      = out_valid && out_ready;
    in_ready = (cnt_q != (AW+1)'(DEPTH));
    out_valid = (cnt_q != '0);
    out_data = mem_q[rd_q];
    wr_d     = push ? wr_q + 1'b1 : wr_q;
    rd_d     = pop ? rd_q + 1'b1 : rd_q;
    cnt_d    = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  fifo_bound_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    cnt_q <= (AW+1)'(DEPTH)) else $error("fifo count overflow");

endmodule

// File: design/ssu_sync.sv
// Three-stage synchroniser with agreement filter
`timescale 1ns/1ps
module ssu_sync (
  input  wire logic sys_clk,
  input  wire logic rst_b,
  input  wire logic raw_in,
  input  wire logic rst_val,
  output logic      clean_out
);

  logic s1_q, s2_q, s3_q, out_q;
  logic s1_d, s2_d, s3_d, out_d;

  // ----------------------------------------------------------------
  // Stages
  // ----------------------------------------------------------------
  always_comb begin
    // Stored relative to the reset level, so reset shows the idle value
    s1_d  = raw_in ^ rst_val;
    s2_d  = s1_q;
    s3_d  = s2_q;
    out_d = (s2_q == s3_q) ? s3_q : out_q;
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_q  <= 1'b0;
      s2_q  <= 1'b0;
      s3_q  <= 1'b0;
      out_q <= 1'b0;
    end else begin
      s1_q  <= s1_d;
      s2_q  <= s2_d;
      s3_q  <= s3_d;
      out_q <= out_d;
    end
  end

  assign clean_out = out_q ^ rst_val;

endmodule

// File: design/ssu_spi_port.sv
// SPI master/slave port of the synchronous serial unit
//
// What the document requires of this block
// [RULE1] Shift out MSb first, shift received bit into the LSb.
// [RULE2] Drive output on programmed clock edge, capture on the opposite.
// [RULE3] Both parties share clock polarity; master starts by clocking.
// [RULE4] Full byte goes to receive buffer; set buffer-full and irq flags.
// [RULE5] Buffer write loads the shift register too; no transmit buffer.
// [RULE6] Buffer write during shifting is dropped and sets collision flag.
// [RULE7] Collision flag must be cleared; writes ignored until then.
// [RULE8] Reading the data buffer clears buffer-full.
// [RULE9] Shift register reachable only through the data buffer.
// [RULE10] Master: buffer write starts an eight-bit exchange at set rate.
// [RULE11] Master keeps sampling input; each byte loads buffer and flags.
// [RULE12] Master rate: clock/4, /16, /64, half timer2, or reload based.
// [RULE13] Control bits pick role, idle level, phase, edge, rate, select.
// [RULE14] Clock polarity bit sets the clock idle level.
// [RULE15] Sample-phase bit picks mid or end of output time capture.
// [RULE16] Edge bit set: output valid before first clock edge.
// [RULE17] Enable bit hands clock, data and select pins to the port.
// [RULE18] Software disables, reconfigures, then re-enables the port.
// [RULE19] Software sets pin directions for inputs and outputs; the port drives sck_oe and sdo_oe itself.
// [RULE20] Status low six bits read-only, upper two writable; status here has three bits, all read-only.
// [RULE21] Unselected slave ignores clock and data, leaves output undriven.
// [RULE22] Master stops clock and deselects slave when finished; the port has no select output, so it only stops the clock.
// [RULE23] Master clock output is fed back as the clock input; the master here clocks its shifter from its own sck_q and ignores sck_in.
// [RULE24] Slave with select: select high or disable clears bit counter.
// [RULE25] Slave with select: output released while select high.
// [RULE26] Slave shifts on external clock; irq flag on last bit.
// [RULE27] Four-bit mode field picks master rate or slave type.
`timescale 1ns/1ps
module ssu_spi_port (
  input  wire logic              sys_clk,
  input  wire logic              rst_b,
  input  wire ssu_pkg::ssu_cfg_t cfg,
  input  wire logic [7:0]        rate_reload_reg,
  input  wire logic              tmr2_tick,
  input  wire logic [7:0]        wr_data,
  input  wire logic              wr_strobe,
  input  wire logic              rd_strobe,
  input  wire logic              clr_collision,
  output logic [7:0]             rd_data,
  output ssu_pkg::ssu_stat_t     status,
  output logic                   port_irq_flag,
  output logic                   rx_valid,
  input  wire logic              rx_ready,
  output logic [7:0]             rx_data,
  input  wire logic              sck_in,
  output logic                   sck_out,
  output logic                   sck_oe,
  input  wire logic              sdi_in,
  output logic                   sdo_out,
  output logic                   sdo_oe,
  input  wire logic              ss_b_in
);

  typedef enum logic [1:0] {SSU_IDLE, SSU_LEAD, SSU_TRAIL} ssu_state_t;

  // Decode role from mode field [RULE27]
  function automatic logic is_master(input logic [3:0] m);
    is_master = (m == ssu_pkg::MODE_MST_DIV4) ||
                (m == ssu_pkg::MODE_MST_DIV16) ||
                (m == ssu_pkg::MODE_MST_DIV64) ||
                (m == ssu_pkg::MODE_MST_TMR2) ||
                (m == ssu_pkg::MODE_MST_RELD);
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic sck_s, sdi_s, ss_b_s;
  ssu_sync u_sck (.sys_clk(sys_clk), .rst_b(rst_b), .raw_in(sck_in),
                  .rst_val(1'b0), .clean_out(sck_s));
  ssu_sync u_sdi (.sys_clk(sys_clk), .rst_b(rst_b), .raw_in(sdi_in),
                  .rst_val(1'b0), .clean_out(sdi_s));
  ssu_sync u_ss  (.sys_clk(sys_clk), .rst_b(rst_b), .raw_in(ss_b_in),
                  .rst_val(1'b1), .clean_out(ss_b_s));

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  ssu_state_t st_q, st_d;
  logic [7:0] shift_q, shift_d;
  logic [7:0] buf_q, buf_d;
  logic [3:0] bits_q, bits_d;
  logic [7:0] div_q, div_d;
  logic       sck_q, sck_d;
  logic       sdo_q, sdo_d;
  logic       full_q, full_d;
  logic       coll_q, coll_d;
  logic       irq_q, irq_d;
  logic       sck_prev_q, sck_prev_d;
  logic       fifo_push;

  logic       master, slave_ss, selected, busy, wr_ok, tick;
  logic       done, lead_edge, trail_edge, sck_rise, sck_fall;
  logic       drive_edge, cap_edge, sdi_bit;
  logic [7:0] half;

  // ----------------------------------------------------------------
  // Rate select
  // ----------------------------------------------------------------
  always_comb begin
    master   = cfg.enable && is_master(cfg.mode); // [RULE13]
    slave_ss = cfg.enable && (cfg.mode == ssu_pkg::MODE_SLV_SS);
    selected = !slave_ss || !ss_b_s; // [RULE21]
    busy     = (st_q != SSU_IDLE);
    case (cfg.mode) // [RULE12]
      ssu_pkg::MODE_MST_DIV16: half = ssu_pkg::DIV16_HALF;
      ssu_pkg::MODE_MST_DIV64: half = ssu_pkg::DIV64_HALF;
      ssu_pkg::MODE_MST_RELD:  half = 8'(rate_reload_reg + 8'h01) << 1;
      default:                 half = ssu_pkg::DIV4_HALF;
    endcase
    if (cfg.mode == ssu_pkg::MODE_MST_TMR2) begin
      tick = tmr2_tick;
    end else begin
      tick = (div_q + 8'h01 >= half);
    end
    sck_rise = sck_s && !sck_prev_q;
    sck_fall = !sck_s && sck_prev_q;
    // Master input is launched by its own clock, so sampled directly
    sdi_bit  = master ? sdi_in : sdi_s; // [RULE11]
  end

  // ----------------------------------------------------------------
  // Shift engine
  // ----------------------------------------------------------------
  always_comb begin
    st_d       = st_q;
    shift_d    = shift_q;
    buf_d      = buf_q;
    bits_d     = bits_q;
    div_d      = div_q;
    sck_d      = sck_q;
    sdo_d      = sdo_q;
    full_d     = full_q;
    coll_d     = coll_q;
    irq_d      = 1'b0;
    sck_prev_d = sck_s;
    done       = 1'b0;
    lead_edge  = 1'b0;
    trail_edge = 1'b0;
    wr_ok      = wr_strobe && !coll_q && !busy;
    if (master) begin
      if (busy) begin
        div_d = tick ? 8'h00 : div_q + 8'h01;
        if (tick) begin
          sck_d = !sck_q;
          if (st_q == SSU_LEAD) begin
            lead_edge = 1'b1;
            st_d = SSU_TRAIL;
          end else begin
            trail_edge = 1'b1;
            st_d = SSU_LEAD;
          end
        end
      end
    end else if (cfg.enable && selected) begin
      // External clock edges; the leading edge leaves idle level [RULE26]
      lead_edge  = cfg.idle_high ? sck_fall : sck_rise;
      trail_edge = cfg.idle_high ? sck_rise : sck_fall;
      if (lead_edge || trail_edge) begin
        st_d = SSU_TRAIL;
      end
    end
    // Edge bit set: drive on trailing edge [RULE2] [RULE16]
    drive_edge = cfg.edge_sel ? trail_edge : lead_edge;
    // Capture on opposite edge, or, in master mode only, at end of output time [RULE15]
    cap_edge   = (master && cfg.sample_end) ? drive_edge :
                 (cfg.edge_sel ? lead_edge : trail_edge);
    if (cap_edge) begin
      shift_d = {shift_q[6:0], sdi_bit}; // [RULE1] [RULE11]
      bits_d  = bits_q + 4'h1;
    end
    // Next bit leaves after a capture on the same edge
    if (drive_edge) begin
      sdo_d = shift_d[7];
    end
    if (bits_d == ssu_pkg::BIT_LAST && bits_q != ssu_pkg::BIT_LAST) begin
      done   = 1'b1;
      buf_d  = shift_d; // [RULE4]
      full_d = 1'b1;
      irq_d  = 1'b1;
    end
    // Master completes the last clock cycle before going idle [RULE10]
    if (bits_d == ssu_pkg::BIT_LAST &&
        (!master || sck_d == cfg.idle_high)) begin
      bits_d = 4'h0;
      st_d   = SSU_IDLE;
      sck_d  = cfg.idle_high;
      div_d  = 8'h00;
    end
    // Buffer write loads shift register directly [RULE5] [RULE9]
    if (wr_ok) begin
      buf_d   = wr_data;
      shift_d = wr_data;
      bits_d  = 4'h0;
      if (cfg.edge_sel) begin
        sdo_d = wr_data[7]; // [RULE16]
      end
      if (master) begin
        st_d = SSU_LEAD; // [RULE10]
      end
    end
    // Collision set wins over clear [RULE6] [RULE7]
    if (clr_collision) begin
      coll_d = 1'b0;
    end
    if (wr_strobe && busy) begin
      coll_d = 1'b1;
    end
    if (rd_strobe && !done) begin
      full_d = 1'b0; // [RULE8]
    end
    // Select high or disable clears the bit count and returns to idle [RULE24]
    if (!cfg.enable || (slave_ss && ss_b_s)) begin
      bits_d = 4'h0;
      st_d   = SSU_IDLE;
      sck_d  = cfg.idle_high; // [RULE14]
      div_d  = 8'h00;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q       <= SSU_IDLE;
      shift_q    <= ssu_pkg::BYTE_RST;
      buf_q      <= ssu_pkg::BYTE_RST;
      bits_q     <= 4'h0;
      div_q      <= 8'h00;
      sck_q      <= 1'b0;
      sdo_q      <= 1'b0;
      full_q     <= 1'b0;
      coll_q     <= 1'b0;
      irq_q      <= 1'b0;
      sck_prev_q <= 1'b0;
    end else begin
      st_q       <= st_d;
      shift_q    <= shift_d;
      buf_q      <= buf_d;
      bits_q     <= bits_d;
      div_q      <= div_d;
      sck_q      <= sck_d;
      sdo_q      <= sdo_d;
      full_q     <= full_d;
      coll_q     <= coll_d;
      irq_q      <= irq_d;
      sck_prev_q <= sck_prev_d;
    end
  end

  // ----------------------------------------------------------------
  // Received byte stream
  // ----------------------------------------------------------------
  assign fifo_push = irq_q;
  ssu_fifo #(.WIDTH(ssu_pkg::BYTE_BITS), .DEPTH(ssu_pkg::FIFO_DEPTH),
             .AW(ssu_pkg::FIFO_AW)) u_fifo (
    .sys_clk  (sys_clk),
    .rst_b    (rst_b),
    .in_valid (fifo_push),
    .in_ready (),
    .in_data  (buf_q),
    .out_valid(rx_valid),
    .out_ready(rx_ready),
    .out_data (rx_data)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_comb begin
    rd_data         = buf_q;
    status          = '{buffer_full: full_q, write_collision: coll_q,
                        busy: busy}; // [RULE20]
    port_irq_flag   = irq_q;
    sck_out         = master ? sck_q : cfg.idle_high;
    sck_oe          = master; // [RULE17] [RULE23]
    sdo_out         = sdo_q;
    sdo_oe          = cfg.enable && selected; // [RULE21] [RULE25]
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence byte_done_s;
    done;
  endsequence

  byte_flags_a: assert property ( // [RULE4]
    @(posedge sys_clk) disable iff (!rst_b)
    byte_done_s |=> full_q && irq_q && buf_q == $past(shift_d))
    else $error("byte end missed flags");
  coll_set_a: assert property ( // [RULE6]
    @(posedge sys_clk) disable iff (!rst_b)
    wr_strobe && busy |=> coll_q) else $error("collision lost");
  coll_block_a: assert property ( // [RULE7]
    @(posedge sys_clk) disable iff (!rst_b)
    coll_q && wr_strobe |=> $stable(buf_q) || $past(done))
    else $error("write taken during collision");
  read_clr_a: assert property ( // [RULE8]
    @(posedge sys_clk) disable iff (!rst_b)
    rd_strobe && !done |=> !full_q) else $error("read kept full");
  wr_load_a: assert property ( // [RULE5]
    @(posedge sys_clk) disable iff (!rst_b)
    wr_ok |=> shift_q == $past(wr_data) && buf_q == $past(wr_data))
    else $error("write not loaded");
  mst_start_a: assert property ( // [RULE10]
    @(posedge sys_clk) disable iff (!rst_b)
    wr_ok && master |=> busy) else $error("exchange not started");
  ss_release_a: assert property ( // [RULE25]
    @(posedge sys_clk) disable iff (!rst_b)
    slave_ss && ss_b_s |-> !sdo_oe) else $error("sdo driven");
  ss_reset_a: assert property ( // [RULE24]
    @(posedge sys_clk) disable iff (!rst_b)
    slave_ss && ss_b_s |=> bits_q == 4'h0) else $error("count kept");
  idle_lvl_a: assert property ( // [RULE14]
    @(posedge sys_clk) disable iff (!rst_b)
    master && !busy && $past(!busy) |-> sck_out == cfg.idle_high)
    else $error("idle level wrong");

endmodule

// File: test/ssu_slave_model.sv
// Behavioural SPI slave facing the port in master mode
`timescale 1ns/1ps
module ssu_slave_model (
  input  wire logic       sck,
  input  wire logic       ss_b,
  input  wire logic       mosi,
  input  wire logic [7:0] tx_byte,
  output logic            miso,
  output logic [7:0]      rx_byte
);
  // ----------------------------------------------------------------
  // Shifter, idle low, capture on rising, drive on falling
  // ----------------------------------------------------------------
  logic [7:0] sh;

  initial begin
    miso    = 1'b0;
    rx_byte = 8'h00;
    sh      = 8'h00;
  end

  always @(negedge ss_b) begin
    sh   = tx_byte;
    miso = sh[7];
  end

  // Released line shows the inverse of the last driven bit
  always @(posedge ss_b) miso = ~miso;

  always @(posedge sck) begin
    if (!ss_b) rx_byte = {rx_byte[6:0], mosi};
  end

  always @(negedge sck) begin
    if (!ss_b) begin
      sh   = {sh[6:0], 1'b0};
      miso = sh[7];
    end
  end
endmodule

// File: test/ssu_testbench.sv
// Self-checking bench for the SPI port
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin \
  fails++; $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module testbench;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam logic [7:0] RELOAD = 8'h05;
  logic               sys_clk, rst_b, tmr2_tick, wr_strobe, rd_strobe;
  logic               clr_collision, port_irq_flag, rx_valid, rx_ready;
  logic               sck_in, sck_out, sck_oe, sdi_in, sdo_out, sdo_oe;
  logic               ss_b_in, m_sck, m_sdi, p_ss_b, p_miso, slv, sel_oe;
  logic [7:0]         wr_data, rd_data, rx_data, p_tx, p_rx;
  ssu_pkg::ssu_cfg_t  cfg;
  ssu_pkg::ssu_stat_t status;
  int                 fails, tests_run, irqs, rises, tk;

  always #20 sys_clk = ~sys_clk;
  assign sck_in = sck_oe ? sck_out : m_sck;
  assign sdi_in = slv ? m_sdi : p_miso;

  always @(posedge sys_clk) begin
    tk        <= (tk == 4) ? 0 : tk + 1;
    tmr2_tick <= (tk == 4);
    if (port_irq_flag === 1'b1) irqs++;
  end
  always @(posedge sck_out) rises++;

  ssu_spi_port dut (.sys_clk(sys_clk), .rst_b(rst_b), .cfg(cfg),
    .rate_reload_reg(RELOAD), .tmr2_tick(tmr2_tick), .wr_data(wr_data),
    .wr_strobe(wr_strobe), .rd_strobe(rd_strobe),
    .clr_collision(clr_collision), .rd_data(rd_data), .status(status),
    .port_irq_flag(port_irq_flag), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .rx_data(rx_data), .sck_in(sck_in),
    .sck_out(sck_out), .sck_oe(sck_oe), .sdi_in(sdi_in),
    .sdo_out(sdo_out), .sdo_oe(sdo_oe), .ss_b_in(ss_b_in));

  ssu_slave_model partner (.sck(sck_in), .ss_b(p_ss_b), .mosi(sdo_out),
    .tx_byte(p_tx), .miso(p_miso), .rx_byte(p_rx));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] b);
    @(posedge sys_clk) begin
      wr_data   <= b;
      wr_strobe <= 1'b1;
    end
    @(posedge sys_clk) wr_strobe <= 1'b0;
  endtask

  task automatic wait_irq(input int lim);
    int k0, i;
    k0 = irqs;
    for (i = 0; i < lim && irqs == k0; i++) @(posedge sys_clk);
    if (irqs == k0) begin
      fails++;
      $display("[FAIL] irq wait exp 1 got 0");
    end
    cyc(2);
  endtask

  task automatic set_cfg(input logic [3:0] m, input logic ih);
    @(posedge sys_clk) cfg <= '{enable: 1'b0, mode: m, idle_high: ih,
                                sample_end: 1'b0, edge_sel: 1'b1};
    cyc(2);
    @(posedge sys_clk) cfg.enable <= 1'b1;
    cyc(8);
  endtask

  task automatic mx(input logic [7:0] ptx, input logic [7:0] b);
    p_tx = ptx;
    @(posedge sys_clk) p_ss_b <= 1'b0;
    wr(b);
    wait_irq(1500);
    @(posedge sys_clk) p_ss_b <= 1'b1;
    cyc(2);
  endtask

  task automatic sl_bits(input logic [7:0] d, input int n,
                         output logic [7:0] got);
    int i;
    got = 8'h00;
    @(posedge sys_clk) ss_b_in <= 1'b0;
    cyc(8);
    sel_oe = sdo_oe;
    for (i = 7; i > 7 - n; i--) begin
      @(posedge sys_clk) m_sdi <= d[i];
      cyc(8);
      got = {got[6:0], sdo_out};
      @(posedge sys_clk) m_sck <= 1'b1;
      cyc(8);
      @(posedge sys_clk) m_sck <= 1'b0;
      cyc(8);
    end
    @(posedge sys_clk) ss_b_in <= 1'b1;
    cyc(8);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_master();
    set_cfg(ssu_pkg::MODE_MST_DIV4, 1'b0);
    `CHK("sck idle", 1'b0, sck_out)
    `CHK("sck oe", 1'b1, sck_oe)
    rises = 0;
    mx(8'h3C, 8'hA5);
    `CHK("rx byte", 8'h3C, rd_data)
    `CHK("full flag", 1'b1, status.buffer_full)
    `CHK("slave got", 8'hA5, p_rx)
    `CHK("sck rises", 8, rises)
    @(posedge sys_clk) rd_strobe <= 1'b1;
    @(posedge sys_clk) rd_strobe <= 1'b0;
    cyc(1);
    `CHK("full clear", 1'b0, status.buffer_full)
    @(posedge sys_clk) cfg.sample_end <= 1'b1;
    mx(8'h96, 8'h69);
    `CHK("end sample", 8'h96, rd_data)
    `CHK("end sent", 8'h69, p_rx)
    set_cfg(ssu_pkg::MODE_MST_DIV4, 1'b1);
    `CHK("sck idle high", 1'b1, sck_out)
  endtask

  task automatic t_rates();
    logic [3:0] md [5];
    int         hf [5];
    int         i, k, h;
    md = '{ssu_pkg::MODE_MST_DIV4, ssu_pkg::MODE_MST_DIV16,
           ssu_pkg::MODE_MST_DIV64, ssu_pkg::MODE_MST_TMR2,
           ssu_pkg::MODE_MST_RELD};
    hf = '{int'(ssu_pkg::DIV4_HALF), int'(ssu_pkg::DIV16_HALF),
           int'(ssu_pkg::DIV64_HALF), 5, 2 * (int'(RELOAD) + 1)};
    for (i = 0; i < 5; i++) begin
      set_cfg(md[i], 1'b0);
      wr(8'h0F);
      h = 0;
      for (k = 0; k < 200 && sck_out !== 1'b1; k++) cyc(1);
      for (k = 0; k < 200 && sck_out === 1'b1; k++) begin
        cyc(1);
        h++;
      end
      `CHK("half period", hf[i], h)
      wait_irq(1500);
    end
  endtask

  task automatic t_collide();
    set_cfg(ssu_pkg::MODE_MST_DIV4, 1'b0);
    p_tx = 8'h00;
    @(posedge sys_clk) p_ss_b <= 1'b0;
    wr(8'h11);
    cyc(4);
    wr(8'h22);
    cyc(1);
    `CHK("collision", 1'b1, status.write_collision)
    wait_irq(600);
    @(posedge sys_clk) p_ss_b <= 1'b1;
    `CHK("kept byte", 8'h11, p_rx)
    wr(8'h33);
    cyc(3);
    `CHK("ignored", 1'b0, status.busy)
    @(posedge sys_clk) clr_collision <= 1'b1;
    @(posedge sys_clk) clr_collision <= 1'b0;
    cyc(1);
    `CHK("cleared", 1'b0, status.write_collision)
    mx(8'h00, 8'h44);
    `CHK("after clear", 8'h44, p_rx)
  endtask

  task automatic t_fifo();
    int         i, n;
    logic [7:0] exp;
    @(posedge sys_clk) rx_ready <= 1'b0;
    for (i = 0; i < 9; i++) mx(8'(8'h40 + i), 8'h00);
    `CHK("stalled", 1'b1, rx_valid)
    n = 0;
    @(posedge sys_clk) rx_ready <= 1'b1;
    repeat (20) begin
      @(negedge sys_clk);
      if (rx_valid === 1'b1) begin
        exp = 8'(8'h40 + n);
        `CHK("fifo data", exp, rx_data)
        n++;
      end
    end
    `CHK("fifo count", ssu_pkg::FIFO_DEPTH, n)
  endtask

  task automatic t_slave();
    logic [7:0] got;
    int         k0;
    slv = 1'b1;
    set_cfg(ssu_pkg::MODE_SLV_SS, 1'b0);
    `CHK("unsel oe", 1'b0, sdo_oe)
    wr(8'hC3);
    k0 = irqs;
    sl_bits(8'h5A, 8, got);
    `CHK("sel oe", 1'b1, sel_oe)
    `CHK("slave out", 8'hC3, got)
    `CHK("slave in", 8'h5A, rd_data)
    sl_bits(8'hFF, 3, got);
    sl_bits(8'h96, 8, got);
    `CHK("resync", 8'h96, rd_data)
    `CHK("slave irqs", k0 + 2, irqs)
    `CHK("oe off", 1'b0, sdo_oe)
  endtask

  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    rst_b = 1'b0;
    {wr_strobe, rd_strobe, clr_collision, tmr2_tick, m_sck, m_sdi} = '0;
    {slv, sel_oe, wr_data, p_tx} = '0;
    {fails, tests_run, irqs, rises, tk} = '0;
    cfg = '0;
    rx_ready = 1'b1;
    ss_b_in = 1'b1;
    p_ss_b = 1'b1;
    repeat (3) @(posedge sys_clk);
    rst_b <= 1'b1;
    cyc(2);
    `CHK("reset status", 3'h0, status)
    `CHK("reset sck oe", 1'b0, sck_oe)
    t_master();
    t_rates();
    t_collide();
    t_fifo();
    t_slave();
    complete_run();
  end

  initial begin
    #800000;
    fails++;
    $display("[FAIL] watchdog exp done got hang");
    complete_run();
  end
endmodule
